// ### rtl/cfs_pkg.sv
// constants and carrier types for the charger fault and throttle status bank
package cfs_pkg;
    localparam logic [7:0] CFS_ADDR_FAULT = 8'h20;
    localparam logic [7:0] CFS_ADDR_THR = 8'h21;
    // charger_fault_status bit positions
    localparam int CFS_B_SYS_OVP = 4;
    localparam int CFS_B_SYS_SHORT = 3;
    localparam int CFS_B_LATCHOFF = 2;
    localparam int CFS_B_REV_OVP = 1;
    localparam int CFS_B_REV_UVP = 0;
    // throttle_status_control bit positions
    localparam int CFS_B_RSV_HI = 15;
    localparam int CFS_B_EXT_EN = 14;
    localparam int CFS_B_WIDTH_HI = 13;
    localparam int CFS_B_WIDTH_LO = 12;
    localparam int CFS_B_CLEAR = 11;
    localparam int CFS_B_RSV_LO = 10;
    localparam int CFS_B_AST_FAIL = 9;
    localparam int CFS_B_AST_EXIT = 8;
    localparam logic [15:0] CFS_FAULT_RESET = 16'h0000;
    localparam logic [15:0] CFS_THR_RESET = 16'ha800;
    localparam logic CFS_RSV_HI_VAL = 1'b1;
    localparam logic CFS_RSV_LO_VAL = 1'b0;
    localparam logic CFS_CLEAR_IDLE = 1'b1;
    localparam logic [1:0] CFS_WIDTH_RESET = 2'h2;
    localparam logic [2:0] CFS_FAIL_TRIES = 3'h7;
    // pulse widths in ns and the clock period
    localparam int CFS_CLK_PERIOD_NS = 100;
    localparam int CFS_T_100US_NS = 100000;
    localparam int CFS_T_1MS_NS = 1000000;
    localparam int CFS_T_5MS_NS = 5000000;
    localparam int CFS_T_10MS_NS = 10000000;
    localparam int CFS_CYC_100US = CFS_T_100US_NS / CFS_CLK_PERIOD_NS;
    localparam int CFS_CYC_1MS = CFS_T_1MS_NS / CFS_CLK_PERIOD_NS;
    localparam int CFS_CYC_5MS = CFS_T_5MS_NS / CFS_CLK_PERIOD_NS;
    localparam int CFS_CYC_10MS = CFS_T_10MS_NS / CFS_CLK_PERIOD_NS;
    localparam int CFS_TMR_W = 17;

    typedef enum logic [1:0] {
        CFS_W_100US = 2'b00,
        CFS_W_1MS = 2'b01,
        CFS_W_10MS = 2'b10,
        CFS_W_5MS = 2'b11
    } cfs_width_t;

    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic rd;
        logic [15:0] wdata;
    } cfs_req_t;

    typedef struct packed {
        logic sys_ovp;
        logic adapter_present;
        logic sys_below_min;
        logic restart_fail;
        logic restart_ok;
        logic latchoff;
        logic rev_ovp;
        logic rev_uvp;
        logic assist_load_fail;
        logic assist_load_ok;
        logic assist_exit;
        logic throttle_trig;
    } cfs_evt_t;
endpackage

// ### rtl/cfs_pulse_timer.sv
// down-counter that times the minimum low pulse on the throttle pin
`timescale 1ns/100ps
module cfs_pulse_timer import cfs_pkg::*; #(
    parameter int W = CFS_TMR_W
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic start,
    input wire logic [W-1:0] load,
    output logic busy,
    output logic [W-1:0] remain
);
    logic [W-1:0] cnt_reg;

    // a new trigger restarts the full width
    always_ff @(posedge clk) begin
        if (!resetn) begin
            cnt_reg <= '0;
        end else if (start) begin
            cnt_reg <= load;
        end else if (cnt_reg != '0) begin
            cnt_reg <= cnt_reg - 1'b1;
        end
    end

    assign busy = (cnt_reg != '0);
    assign remain = cnt_reg;
endmodule

// ### rtl/cfs_status_bank.sv
// charger fault latches, throttle status register and throttle pin control
//
// Notes on behaviour
// [RULE_01] overvoltage sets bit 4, converter held off
// [RULE_02] overvoltage flag cleared by zero write or unplug
// [RULE_03] bit 3 after seven failed restarts below limit
// [RULE_04] short fault clears only by written zero
// [RULE_05] latched-off power path sets bit 2
// [RULE_06] bits 2..0 latch, cleared by host read
// [RULE_07] throttle register resets A800h, reserved bits fixed
// [RULE_08] extension enable holds pin low until clear
// [RULE_09] width field sets minimum pulse when not extending
// [RULE_10] written zero to clear bit releases pin
// [RULE_11] seven assist load failures set bit 9, lockout
// [RULE_12] assist exit sets bit 8, pin held low
// [RULE_13] writes to read-only bits ignored; zeros clear
`timescale 1ns/100ps
module cfs_status_bank import cfs_pkg::*; #(
    parameter int CYC_100US = CFS_CYC_100US,
    parameter int CYC_1MS = CFS_CYC_1MS,
    parameter int CYC_5MS = CFS_CYC_5MS,
    parameter int CYC_10MS = CFS_CYC_10MS
) (
    input wire logic CLK,
    input wire logic RESETN,
    input wire cfs_req_t REG_REQ,
    input wire cfs_evt_t EVT,
    output logic [15:0] REG_RDATA,
    output logic REG_RVALID,
    output logic THROTTLE_PIN,
    output logic CONVERTER_EN,
    output logic ASSIST_LOCKOUT
);
    logic ovp_reg, short_reg, latchoff_reg, rovp_reg, ruvp_reg;
    logic ext_en_reg, hold_reg, fail_reg, exit_reg, pin_reg;
    cfs_width_t width_reg;
    logic [2:0] rst_cnt_reg, ast_cnt_reg;
    logic [15:0] rdata_reg;
    logic rvalid_reg;
    logic wr_fault, wr_thr, rd_fault;
    logic [15:0] fault_view, thr_view;
    logic tmr_start, tmr_busy;
    logic [CFS_TMR_W-1:0] tmr_load, tmr_remain;
    logic short_set, fail_set;

    assign wr_fault = REG_REQ.wr && (REG_REQ.addr == CFS_ADDR_FAULT);
    assign wr_thr = REG_REQ.wr && (REG_REQ.addr == CFS_ADDR_THR);
    assign rd_fault = REG_REQ.rd && (REG_REQ.addr == CFS_ADDR_FAULT);

    // overvoltage: set wins over a clear while the condition persists
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            ovp_reg <= 1'b0;
        end else if (EVT.sys_ovp) begin
            ovp_reg <= 1'b1; // see [RULE_01]
        end else if (!EVT.adapter_present) begin
            ovp_reg <= 1'b0; // see [RULE_02]
        end else if (wr_fault && !REG_REQ.wdata[CFS_B_SYS_OVP]) begin
            ovp_reg <= 1'b0; // see [RULE_02]
        end
    end

    // converter stays off until the latch is gone, not just the condition
    assign CONVERTER_EN = !ovp_reg; // see [RULE_01]

    // consecutive restart failures; a good restart starts the count over
    // count parks at seven, so a later failure with the rail low still latches
    assign short_set = EVT.restart_fail && EVT.sys_below_min
        && (rst_cnt_reg >= CFS_FAIL_TRIES - 3'h1);
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            rst_cnt_reg <= '0;
        end else if (EVT.restart_ok || short_set) begin
            rst_cnt_reg <= '0;
        end else if (EVT.restart_fail && rst_cnt_reg != CFS_FAIL_TRIES) begin
            rst_cnt_reg <= rst_cnt_reg + 3'h1; // see [RULE_03]
        end
    end

    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            short_reg <= 1'b0;
        end else if (short_set) begin
            short_reg <= 1'b1; // see [RULE_03]
        end else if (wr_fault && !REG_REQ.wdata[CFS_B_SYS_SHORT]) begin
            short_reg <= 1'b0; // see [RULE_04]
        end
    end

    // read-to-clear faults; an event in the read cycle survives the read
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            latchoff_reg <= 1'b0;
            rovp_reg <= 1'b0;
            ruvp_reg <= 1'b0;
        end else begin
            latchoff_reg <= EVT.latchoff || (latchoff_reg && !rd_fault); // see [RULE_05]
            rovp_reg <= EVT.rev_ovp || (rovp_reg && !rd_fault); // see [RULE_06]
            ruvp_reg <= EVT.rev_uvp || (ruvp_reg && !rd_fault); // see [RULE_06]
        end
    end

    // throttle control fields
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            ext_en_reg <= 1'b0; // see [RULE_08]
            width_reg <= cfs_width_t'(CFS_WIDTH_RESET); // see [RULE_07]
        end else if (wr_thr) begin
            ext_en_reg <= REG_REQ.wdata[CFS_B_EXT_EN];
            width_reg <= cfs_width_t'(REG_REQ.wdata[CFS_B_WIDTH_HI:CFS_B_WIDTH_LO]);
        end
    end

    // extended pulse: the clear bit itself never stores a zero
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            hold_reg <= 1'b0;
        end else if (EVT.throttle_trig && ext_en_reg) begin
            hold_reg <= 1'b1; // see [RULE_08]
        end else if (wr_thr && !REG_REQ.wdata[CFS_B_CLEAR]) begin
            hold_reg <= 1'b0; // see [RULE_10]
        end
    end

    // assist mode failure counting and lockout
    assign fail_set = EVT.assist_load_fail && (ast_cnt_reg == CFS_FAIL_TRIES - 3'h1);
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            ast_cnt_reg <= '0;
        end else if (EVT.assist_load_ok || fail_set) begin
            ast_cnt_reg <= '0;
        end else if (EVT.assist_load_fail) begin
            ast_cnt_reg <= ast_cnt_reg + 3'h1; // see [RULE_11]
        end
    end

    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            fail_reg <= 1'b0;
        end else if (fail_set) begin
            fail_reg <= 1'b1; // see [RULE_11]
        end else if (wr_thr && !REG_REQ.wdata[CFS_B_AST_FAIL]) begin
            fail_reg <= 1'b0; // see [RULE_13]
        end
    end

    assign ASSIST_LOCKOUT = fail_reg;

    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            exit_reg <= 1'b0;
        end else if (EVT.assist_exit) begin
            exit_reg <= 1'b1; // see [RULE_12]
        end else if (wr_thr && !REG_REQ.wdata[CFS_B_AST_EXIT]) begin
            exit_reg <= 1'b0; // see [RULE_13]
        end
    end

    // minimum width only applies when extension is off
    always_comb begin
        case (width_reg)
            CFS_W_100US: tmr_load = CFS_TMR_W'(CYC_100US); // see [RULE_09]
            CFS_W_1MS: tmr_load = CFS_TMR_W'(CYC_1MS);
            CFS_W_10MS: tmr_load = CFS_TMR_W'(CYC_10MS);
            CFS_W_5MS: tmr_load = CFS_TMR_W'(CYC_5MS);
            default: tmr_load = CFS_TMR_W'(CYC_10MS);
        endcase
    end
    assign tmr_start = EVT.throttle_trig && !ext_en_reg;

    cfs_pulse_timer #(
        .W(CFS_TMR_W)
    ) u_timer (
        .clk(CLK),
        .resetn(RESETN),
        .start(tmr_start),
        .load(tmr_load),
        .busy(tmr_busy),
        .remain(tmr_remain)
    );

    // pin is registered, so it follows its causes one cycle late
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            pin_reg <= 1'b1;
        end else begin
            pin_reg <= !(tmr_busy || hold_reg || exit_reg); // see [RULE_08] [RULE_12]
        end
    end
    assign THROTTLE_PIN = pin_reg;

    // read views; reserved and clear bits are constants, never stored
    always_comb begin
        fault_view = CFS_FAULT_RESET;
        fault_view[CFS_B_SYS_OVP] = ovp_reg;
        fault_view[CFS_B_SYS_SHORT] = short_reg;
        fault_view[CFS_B_LATCHOFF] = latchoff_reg;
        fault_view[CFS_B_REV_OVP] = rovp_reg;
        fault_view[CFS_B_REV_UVP] = ruvp_reg;
        thr_view = 16'h0000;
        thr_view[CFS_B_RSV_HI] = CFS_RSV_HI_VAL; // see [RULE_07]
        thr_view[CFS_B_EXT_EN] = ext_en_reg;
        thr_view[CFS_B_WIDTH_HI:CFS_B_WIDTH_LO] = width_reg;
        thr_view[CFS_B_CLEAR] = CFS_CLEAR_IDLE;
        thr_view[CFS_B_RSV_LO] = CFS_RSV_LO_VAL; // see [RULE_13]
        thr_view[CFS_B_AST_FAIL] = fail_reg;
        thr_view[CFS_B_AST_EXIT] = exit_reg;
    end

    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            rdata_reg <= '0;
            rvalid_reg <= 1'b0;
        end else begin
            rvalid_reg <= REG_REQ.rd;
            if (REG_REQ.rd) begin
                case (REG_REQ.addr)
                    CFS_ADDR_FAULT: rdata_reg <= fault_view;
                    CFS_ADDR_THR: rdata_reg <= thr_view;
                    default: rdata_reg <= 16'h0000;
                endcase
            end
        end
    end
    assign REG_RDATA = rdata_reg;
    assign REG_RVALID = rvalid_reg;

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESETN);

    sequence s_seventh_fail;
        EVT.assist_load_fail && !EVT.assist_load_ok && ast_cnt_reg == 3'h6;
    endsequence
    sequence s_host_clear_pulse;
        ext_en_reg && wr_thr && !REG_REQ.wdata[CFS_B_CLEAR] && !EVT.throttle_trig;
    endsequence

    AST_OVP_SET: assert property (EVT.sys_ovp |=> ovp_reg && !CONVERTER_EN) // see [RULE_01]
        else $error("overvoltage did not latch or converter stayed on");
    AST_OVP_KEEP: assert property (ovp_reg && EVT.adapter_present && !wr_fault // see [RULE_02]
        |=> ovp_reg)
        else $error("overvoltage flag dropped without clear");
    AST_SHORT_READ: assert property (short_reg && rd_fault && !wr_fault // see [RULE_04]
        |=> short_reg)
        else $error("short fault cleared by a read");
    AST_SHORT_SET: assert property (EVT.restart_fail && EVT.sys_below_min // see [RULE_03]
        && rst_cnt_reg == 3'h6 && !EVT.restart_ok |=> short_reg)
        else $error("short fault not set on seventh failure");
    AST_RD_CLR: assert property (rd_fault && !EVT.latchoff // see [RULE_06]
        && !EVT.rev_ovp && !EVT.rev_uvp |=> !latchoff_reg && !rovp_reg && !ruvp_reg)
        else $error("read did not clear latched faults");
    AST_RESET_VAL: assert property (disable iff (1'b0) !RESETN // see [RULE_07]
        |=> thr_view == CFS_THR_RESET)
        else $error("throttle register not at reset value");
    AST_EXT_HOLD: assert property (EVT.throttle_trig && ext_en_reg // see [RULE_08]
        |=> hold_reg ##1 !THROTTLE_PIN)
        else $error("extended pulse did not pull pin low");
    AST_WIDTH_LOAD: assert property (tmr_start && width_reg == CFS_W_100US // see [RULE_09]
        |=> tmr_remain == CFS_TMR_W'(CYC_100US))
        else $error("pulse width load wrong");
    AST_CLEAR_REL: assert property (s_host_clear_pulse // see [RULE_10]
        ##1 (!tmr_busy && !exit_reg) |=> THROTTLE_PIN)
        else $error("pin not released after clear");
    AST_ASSIST_FAIL: assert property (s_seventh_fail // see [RULE_11]
        |=> fail_reg && ASSIST_LOCKOUT)
        else $error("assist failure flag not set");
    AST_EXIT_LOW: assert property (exit_reg |=> !THROTTLE_PIN) // see [RULE_12]
        else $error("pin high while assist exit flag set");
    AST_RO_BITS: assert property (REG_REQ.rd && REG_REQ.addr == CFS_ADDR_THR // see [RULE_13]
        |=> REG_RVALID && REG_RDATA[CFS_B_RSV_HI] == CFS_RSV_HI_VAL
        && REG_RDATA[CFS_B_RSV_LO] == CFS_RSV_LO_VAL
        && REG_RDATA[CFS_B_CLEAR] == CFS_CLEAR_IDLE)
        else $error("reserved bit changed by write");
endmodule

// ### sim/cfs_host_model.sv
// host controller model issuing register commands
`timescale 1ns/100ps
module cfs_host_model import cfs_pkg::*; (
    input wire logic clk,
    output cfs_req_t req,
    input wire logic [15:0] rdata,
    input wire logic rvalid
);
    initial begin
        req = '0;
    end
    // released lines flip so a stale value is never mistaken for data
    task automatic release_bus();
        req.wr = 1'b0;
        req.rd = 1'b0;
        req.addr = ~req.addr;
        req.wdata = ~req.wdata;
    endtask
    // written zeros are how the host clears the overvoltage and short latches; bits 2..0 clear on a read
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        #10;
        req.addr = a;
        req.wdata = d;
        req.wr = 1'b1;
        @(posedge clk);
        #10;
        release_bus();
    endtask
    task automatic rd(input logic [7:0] a, output logic [15:0] d, output logic ok);
        @(posedge clk);
        #10;
        req.addr = a;
        req.rd = 1'b1;
        @(posedge clk);
        #10;
        d = rdata;
        ok = rvalid;
        release_bus();
    endtask
endmodule

// ### sim/testbench.sv
// self-checking bench for the fault and throttle status bank
`timescale 1ns/100ps
module testbench import cfs_pkg::*;;
    localparam cfs_evt_t E_OVP = 12'h800;
    localparam cfs_evt_t E_ADPT = 12'h400;
    localparam cfs_evt_t E_RFAIL = 12'h100;
    localparam cfs_evt_t E_ROK = 12'h080;
    localparam cfs_evt_t E_AOK = 12'h004;
    localparam cfs_evt_t E_LATCH3 = 12'h070;
    localparam cfs_evt_t E_AFAIL = 12'h008;
    localparam cfs_evt_t E_AEXIT = 12'h002;
    localparam cfs_evt_t E_TRIG = 12'h001;
    localparam int LOW_CYC [4] = '{4, 8, 16, 12};
    logic clk, resetn, rvalid, pin, conv_en, lockout;
    cfs_req_t req;
    cfs_evt_t evt;
    logic [15:0] rdata, got;
    int n_errors, comparisons, seed, m20, m21, i;

    cfs_status_bank #(.CYC_100US(4), .CYC_1MS(8), .CYC_5MS(12), .CYC_10MS(16)) dut_u (
        .CLK(clk), .RESETN(resetn), .REG_REQ(req), .EVT(evt), .REG_RDATA(rdata),
        .REG_RVALID(rvalid), .THROTTLE_PIN(pin), .CONVERTER_EN(conv_en),
        .ASSIST_LOCKOUT(lockout));
    cfs_host_model host_u (.clk(clk), .req(req), .rdata(rdata), .rvalid(rvalid));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic complete_run();
        $display("comparisons %0d n_errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        comparisons++;
        if (g !== e) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #10;
    endtask
    // expected view comes from the integer model, never from the design
    task automatic rd_chk(input logic [7:0] a);
        logic [15:0] d;
        logic ok;
        int e;
        e = (a == CFS_ADDR_FAULT) ? m20 : (a == CFS_ADDR_THR) ? m21 : 0;
        host_u.rd(a, d, ok);
        chk({15'h0, ok}, 16'h0001);
        chk(d, 16'(e));
        if (a == CFS_ADDR_FAULT) m20 = m20 & 32'hfff8;
    endtask
    task automatic wr_m(input logic [7:0] a, input logic [15:0] d);
        host_u.wr(a, d);
        if (a == CFS_ADDR_FAULT) m20 = m20 & (32'(d) | 32'hffe7);
        if (a == CFS_ADDR_THR) m21 = 32'h8800 | (d & 16'h7000) | (m21 & d & 16'h0300);
    endtask
    task automatic pulse(input cfs_evt_t m, input int n);
        repeat (n) begin
            tick(1);
            evt = evt | m;
            tick(1);
            evt = evt & ~m;
        end
    endtask
    task automatic width_run(input logic [1:0] w);
        int n;
        wr_m(CFS_ADDR_THR, {2'b00, w, 12'h800});
        pulse(E_TRIG, 1);
        n = 0;
        for (int t = 0; t < 40; t++) begin
            tick(1);
            if (pin === 1'b0) n++;
        end
        chk(16'(n), 16'(LOW_CYC[w]));
    endtask

    // cut off a hang; the whole sequence needs well under 3 ms
    initial begin
        #3000000;
        n_errors++;
        complete_run();
    end

    initial begin
        seed = 32'h5318;
        evt = E_ADPT;
        n_errors = 0;
        comparisons = 0;
        m20 = 0;
        m21 = 32'ha800;
        resetn = 1'b0;
        tick(12);
        resetn = 1'b1;
        rd_chk(CFS_ADDR_FAULT);
        rd_chk(CFS_ADDR_THR);
        rd_chk(8'h22);
        evt = evt | E_OVP;
        tick(3);
        chk({15'h0, conv_en}, 16'h0000);
        evt = evt & ~E_OVP;
        m20 = 32'h0010;
        rd_chk(CFS_ADDR_FAULT);
        chk({15'h0, conv_en}, 16'h0000);
        wr_m(CFS_ADDR_FAULT, 16'h0000);
        tick(1);
        chk({15'h0, conv_en}, 16'h0001);
        evt = evt | E_OVP;
        tick(2);
        evt = '0;
        tick(2);
        chk({15'h0, conv_en}, 16'h0001);
        evt = E_ADPT;
        rd_chk(CFS_ADDR_FAULT);
        pulse(E_LATCH3, 1);
        m20 = m20 | 7;
        rd_chk(CFS_ADDR_FAULT);
        rd_chk(CFS_ADDR_FAULT);
        // a good restart in between must start the count over
        evt = evt | 12'h200;
        pulse(E_RFAIL, 3);
        pulse(E_ROK, 1);
        pulse(E_RFAIL, 6);
        rd_chk(CFS_ADDR_FAULT);
        pulse(E_RFAIL, 1);
        m20 = m20 | 8;
        rd_chk(CFS_ADDR_FAULT);
        evt = E_ADPT;
        pulse(E_AFAIL, 3);
        pulse(E_AOK, 1);
        pulse(E_AFAIL, 6);
        chk({15'h0, lockout}, 16'h0000);
        pulse(E_AFAIL, 1);
        m21 = m21 | 32'h0200;
        chk({15'h0, lockout}, 16'h0001);
        // ones and reserved bits must leave the latches alone
        for (i = 0; i < 4; i++) begin
            got = 16'($random(seed));
            wr_m(CFS_ADDR_FAULT, got | 16'h0018);
            wr_m(CFS_ADDR_THR, (got & 16'h37ff) | 16'h0b00);
            rd_chk(CFS_ADDR_FAULT);
            rd_chk(CFS_ADDR_THR);
        end
        wr_m(CFS_ADDR_FAULT, 16'h0000);
        rd_chk(CFS_ADDR_FAULT);
        wr_m(CFS_ADDR_THR, 16'h2800);
        chk({15'h0, lockout}, 16'h0000);
        for (i = 0; i < 4; i++) width_run(2'(i));
        wr_m(CFS_ADDR_THR, 16'h4800);
        pulse(E_TRIG, 1);
        tick(30);
        chk({15'h0, pin}, 16'h0000);
        rd_chk(CFS_ADDR_THR);
        wr_m(CFS_ADDR_THR, 16'h4000);
        tick(2);
        chk({15'h0, pin}, 16'h0001);
        rd_chk(CFS_ADDR_THR);
        pulse(E_AEXIT, 1);
        m21 = m21 | 32'h0100;
        tick(40);
        chk({15'h0, pin}, 16'h0000);
        rd_chk(CFS_ADDR_THR);
        wr_m(CFS_ADDR_THR, 16'h2800);
        tick(2);
        chk({15'h0, pin}, 16'h0001);
        // a mid-run reset must bring back the power-on view
        wr_m(CFS_ADDR_THR, 16'h5800);
        rd_chk(CFS_ADDR_THR);
        resetn = 1'b0;
        tick(2);
        resetn = 1'b1;
        m20 = 0;
        m21 = 32'ha800;
        rd_chk(CFS_ADDR_THR);
        rd_chk(CFS_ADDR_FAULT);
        complete_run();
    end
endmodule
